// file: dv/bspc_sink_model.sv
// Far-side sink model taking encoder bytes and decoder beats
`timescale 1ns/1ps
`default_nettype none
module bspc_sink_model (
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 reset_n,
    // Slow-sink request from the bench
    input  wire logic                 stall,
    // Encoder byte side
    input  wire logic                 enc_out_valid,
    input  wire logic [7:0]           enc_out_data,
    output var  logic                 enc_out_ready,
    // Decoder packet side
    input  wire logic                 dec_out_valid,
    input  wire bspc_pkg::bspc_beat_s dec_out_beat,
    output var  logic                 dec_out_ready
);
    logic [7:0]           enc_q[$];  // Bytes taken, read by the bench
    bspc_pkg::bspc_beat_s dec_q[$];  // Beats taken, read by the bench

    // Ready toggles while stalling, so held outputs are stressed
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            enc_out_ready <= 1'b0;
            dec_out_ready <= 1'b0;
        end else begin
            enc_out_ready <= stall ? ~enc_out_ready : 1'b1;
            dec_out_ready <= stall ? ~dec_out_ready : 1'b1;
        end
    end

    // zero ready latency
    // A unit is taken at the edge where valid and ready are both high
    always @(posedge core_clk) begin
        if (reset_n && enc_out_valid && enc_out_ready) begin
            enc_q.push_back(enc_out_data);
        end
        if (reset_n && dec_out_valid && dec_out_ready) begin
            dec_q.push_back(dec_out_beat);
        end
    end
endmodule // bspc_sink_model
`default_nettype wire

// file: dv/tb_top.sv
// Self-checking bench for the byte/packet codec
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic                 core_clk;      // 20 MHz clock
    logic                 reset_n;       // Active-low reset
    logic                 stall;         // Slow far side
    logic                 dec_in_valid;  // Byte offered to decoder
    logic [7:0]           dec_in_data;   // Byte value
    logic                 dec_in_ready;  // Decoder takes byte
    logic                 dec_out_valid; // Beat from decoder
    bspc_pkg::bspc_beat_s dec_out_beat;  // Beat contents
    logic                 dec_out_ready; // Sink takes beat
    logic                 enc_in_valid;  // Beat offered to encoder
    bspc_pkg::bspc_beat_s enc_in_beat;   // Beat contents
    logic                 enc_in_ready;  // Encoder takes beat
    logic                 enc_out_valid; // Byte from encoder
    logic [7:0]           enc_out_data;  // Byte value
    logic                 enc_out_ready; // Sink takes byte
    int                   bad_count;     // Mismatches seen
    int                   cmp_count;     // Comparisons made
    bspc_pkg::bspc_beat_s eb[$];         // Beats to encode
    logic [7:0]           ee[$];         // Expected encoder bytes
    logic [7:0]           db[$];         // Bytes to decode
    bspc_pkg::bspc_beat_s de[$];         // Expected decoder beats

    // Design under test
    bspc_codec i_dut (.core_clk(core_clk), .reset_n(reset_n),
        .dec_in_valid(dec_in_valid), .dec_in_data(dec_in_data),
        .dec_in_ready(dec_in_ready), .dec_out_valid(dec_out_valid),
        .dec_out_beat(dec_out_beat), .dec_out_ready(dec_out_ready),
        .enc_in_valid(enc_in_valid), .enc_in_beat(enc_in_beat),
        .enc_in_ready(enc_in_ready), .enc_out_valid(enc_out_valid),
        .enc_out_data(enc_out_data), .enc_out_ready(enc_out_ready));

    // Far-side sink for both outputs
    bspc_sink_model i_part (.core_clk(core_clk), .reset_n(reset_n),
        .stall(stall), .enc_out_valid(enc_out_valid),
        .enc_out_data(enc_out_data), .enc_out_ready(enc_out_ready),
        .dec_out_valid(dec_out_valid), .dec_out_beat(dec_out_beat),
        .dec_out_ready(dec_out_ready));

    // Clock generator
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // Build one packet-side beat
    function automatic bspc_pkg::bspc_beat_s bt(logic [7:0] d,
        logic [7:0] c, logic s, logic e);
        bt = '{data: d, channel: c, sop: s, eop: e};
    endfunction

    // Verdict and end of run
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Reset held three cycles; stall dropped so sinks start prompt
    task automatic do_reset();
        reset_n <= 1'b0;
        stall   <= 1'b0;
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
    endtask

    // Valid held through the whole list, so it is never re-raised
    task automatic enc_run();
        int n;
        @(posedge core_clk);
        foreach (eb[i]) begin
            enc_in_valid <= 1'b1;
            enc_in_beat  <= eb[i];
            n = 0;
            @(negedge core_clk);
            while (enc_in_ready !== 1'b1 && n < 200) begin
                @(negedge core_clk);
                n++;
            end
            if (n >= 200) begin
                bad_count++;
                $display("MISMATCH %0t encoder input never ready", $time);
            end
            @(posedge core_clk);
        end
        enc_in_valid <= 1'b0;
        eb.delete();
    endtask

    // Same handshake on the decoder byte input
    task automatic dec_run();
        int n;
        @(posedge core_clk);
        foreach (db[i]) begin
            dec_in_valid <= 1'b1;
            dec_in_data  <= db[i];
            n = 0;
            @(negedge core_clk);
            while (dec_in_ready !== 1'b1 && n < 200) begin
                @(negedge core_clk);
                n++;
            end
            if (n >= 200) begin
                bad_count++;
                $display("MISMATCH %0t decoder input never ready", $time);
            end
            @(posedge core_clk);
        end
        dec_in_valid <= 1'b0;
        db.delete();
    endtask

    // Drain, then compare; quiet cycles expose surplus output
    task automatic chk_enc();
        int n;
        n = 0;
        while (i_part.enc_q.size() < ee.size() && n < 300) begin
            @(posedge core_clk);
            n++;
        end
        repeat (6) @(posedge core_clk);
        cmp_count++;
        if (i_part.enc_q.size() != ee.size()) begin
            bad_count++;
            $display("MISMATCH %0t encoder byte count", $time);
        end else begin
            foreach (ee[i]) begin
                cmp_count++;
                if (i_part.enc_q[i] !== ee[i]) begin
                    bad_count++;
                    $display("MISMATCH %0t encoder byte %0d", $time, i);
                end
            end
        end
        i_part.enc_q.delete();
        ee.delete();
    endtask

    // Beat list comparison, flags and channel included
    task automatic chk_dec();
        int n;
        n = 0;
        while (i_part.dec_q.size() < de.size() && n < 300) begin
            @(posedge core_clk);
            n++;
        end
        repeat (6) @(posedge core_clk);
        cmp_count++;
        if (i_part.dec_q.size() != de.size()) begin
            bad_count++;
            $display("MISMATCH %0t decoder beat count", $time);
        end else begin
            foreach (de[i]) begin
                cmp_count++;
                if (i_part.dec_q[i] !== de[i]) begin
                    bad_count++;
                    $display("MISMATCH %0t decoder beat %0d", $time, i);
                end
            end
        end
        i_part.dec_q.delete();
        de.delete();
    endtask

    // Lone beat right after reset gets a full header
    task automatic t_enc_header();
        eb = '{bt(8'h41, 8'h01, 1'b1, 1'b1)};
        ee = '{8'h7C, 8'h01, 8'h7A, 8'h7B, 8'h41};
        enc_run();
        chk_enc();
    endtask

    // Special channel and data bytes under a stalling sink
    task automatic t_enc_escape();
        stall <= 1'b1;
        eb = '{bt(8'h7A, 8'h7D, 1'b1, 1'b0), bt(8'h7B, 8'h7D, 1'b0, 1'b1)};
        ee = '{8'h7C, 8'h7D, 8'h5D, 8'h7A, 8'h7D, 8'h5A, 8'h7B, 8'h7D,
               8'h5B};
        enc_run();
        chk_enc();
        stall <= 1'b0;
    endtask

    // Channel switch inside a packet
    task automatic t_enc_chan();
        eb = '{bt(8'h10, 8'h02, 1'b1, 1'b0), bt(8'h11, 8'h03, 1'b0, 1'b0),
               bt(8'h12, 8'h03, 1'b0, 1'b1)};
        ee = '{8'h7C, 8'h02, 8'h7A, 8'h10, 8'h7C, 8'h03, 8'h11, 8'h7B,
               8'h12};
        enc_run();
        chk_enc();
    endtask

    // Channel, two-beat packet, then a single-beat packet, stalled
    task automatic t_dec_basic();
        stall <= 1'b1;
        db = '{8'h7C, 8'h05, 8'h7A, 8'h41, 8'h7B, 8'h42, 8'h7A, 8'h7B,
               8'h43};
        de = '{bt(8'h41, 8'h05, 1'b1, 1'b0), bt(8'h42, 8'h05, 1'b0, 1'b1),
               bt(8'h43, 8'h05, 1'b1, 1'b1)};
        dec_run();
        chk_dec();
        stall <= 1'b0;
    endtask

    // Escaped bytes look special yet stay payload or channel
    task automatic t_dec_escape();
        db = '{8'h7D, 8'h5A, 8'h7D, 8'h5D, 8'h7C, 8'h7D, 8'h5C, 8'h7D,
               8'h5B, 8'h41};
        de = '{bt(8'h7A, 8'h05, 1'b0, 1'b0), bt(8'h7D, 8'h05, 1'b0, 1'b0),
               bt(8'h7B, 8'h7C, 1'b0, 1'b0), bt(8'h41, 8'h7C, 1'b0, 1'b0)};
        dec_run();
        chk_dec();
    endtask

    // Reset in mid-packet clears pending marks and channel history
    task automatic t_reset_mid();
        eb = '{bt(8'h66, 8'h04, 1'b1, 1'b0)};
        ee = '{8'h7C, 8'h04, 8'h7A, 8'h66};
        enc_run();
        chk_enc();
        db = '{8'h7A};
        dec_run();
        do_reset();
        eb = '{bt(8'h55, 8'h04, 1'b0, 1'b1)};
        ee = '{8'h7C, 8'h04, 8'h7B, 8'h55};
        enc_run();
        chk_enc();
        db = '{8'h44};
        de = '{bt(8'h44, 8'h00, 1'b0, 1'b0)};
        dec_run();
        chk_dec();
    endtask

    // Main sequence
    initial begin
        bad_count    = 0;
        cmp_count    = 0;
        reset_n      = 1'b0;
        stall        = 1'b0;
        dec_in_valid = 1'b0;
        dec_in_data  = 8'h00;
        enc_in_valid = 1'b0;
        enc_in_beat  = '0;
        do_reset();
        t_enc_header();
        t_enc_escape();
        t_enc_chan();
        t_dec_basic();
        t_dec_escape();
        t_reset_mid();
        tally_and_finish();
    end

    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        #1000000;
        bad_count++;
        $display("MISMATCH %0t watchdog expired", $time);
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire

// file: include/bspc_pkg.sv
// Shared constants and stream carriers for the byte/packet codec
package bspc_pkg;
    // Special characters on the byte side
    localparam logic [7:0] BSPC_ESC  = 8'h7D;
    localparam logic [7:0] BSPC_SOP  = 8'h7A;
    localparam logic [7:0] BSPC_EOP  = 8'h7B;
    localparam logic [7:0] BSPC_CHAN = 8'h7C;
    localparam logic [7:0] BSPC_XOR  = 8'h20;
    // Reset values
    localparam logic [7:0] BSPC_BYTE_RST = 8'h00;
    localparam logic [7:0] BSPC_CHAN_RST = 8'h00;

    // Packet side beat
    typedef struct packed {
        logic [7:0] data;     // Payload symbol
        logic [7:0] channel;  // Channel number
        logic       sop;      // First beat of packet
        logic       eop;      // Last beat of packet
    } bspc_beat_s;

    // Encoder emission states
    typedef enum logic [2:0] {
        BSPC_E_IDLE,
        BSPC_E_CHI,
        BSPC_E_CHESC,
        BSPC_E_CHNUM,
        BSPC_E_SOP,
        BSPC_E_EOP,
        BSPC_E_DESC,
        BSPC_E_DATA
    } bspc_enc_state_e;
endpackage : bspc_pkg

// file: logic/bspc_codec.sv
// Top of byte/packet codec: encoder plus decoder instance
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Eight-bit symbols, ready latency zero
// - Channel field holds up to 256 channels
// - Packet markers only on packet ports
// - Decode priority escape, start, end, channel
// - Escape dropped, next byte xored 0x20
// - Start byte dropped, next payload first
// - End byte dropped, next payload last
// - Single beat raises first and last
// - Channel byte dropped, next byte channel
// - Start emits channel mark, number, start
// - End mark precedes final data byte
// - Channel change mid packet reinserts channel
// - Special data byte escaped and xored
module bspc_codec (
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 reset_n,
    // Decoder byte sink
    input  wire logic                 dec_in_valid,
    input  wire logic [7:0]           dec_in_data,
    output var  logic                 dec_in_ready,
    // Decoder packet source
    output var  logic                 dec_out_valid,
    output var  bspc_pkg::bspc_beat_s dec_out_beat,
    input  wire logic                 dec_out_ready,
    // Encoder packet sink
    input  wire logic                 enc_in_valid,
    input  wire bspc_pkg::bspc_beat_s enc_in_beat,
    output var  logic                 enc_in_ready,
    // Encoder byte source
    output var  logic                 enc_out_valid,
    output var  logic [7:0]           enc_out_data,
    input  wire logic                 enc_out_ready
);
    bspc_pkg::bspc_enc_state_e st_q;  // Emission step
    logic [7:0] chan_q;        // Last channel sent
    logic       hdr_q;         // Channel known to far end
    logic       free;          // Output register can load
    logic       emit;          // Load a byte this cycle
    logic [7:0] byte_d;        // Byte to load
    logic       acc;           // Input beat accepted
    logic       chg;           // Channel must be (re)sent
    logic       ch_sp;         // Channel number is special
    logic       d_sp;          // Data byte is special

    // Decoder half
    // markers only on packet ports
    bspc_decoder u_dec (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .in_valid  (dec_in_valid),
        .in_data   (dec_in_data),
        .in_ready  (dec_in_ready),
        .out_valid (dec_out_valid),
        .out_beat  (dec_out_beat),
        .out_ready (dec_out_ready)
    );

    // Special character test for channel and data
    function automatic logic is_sp(input logic [7:0] b);
        is_sp = (b == bspc_pkg::BSPC_ESC) || (b == bspc_pkg::BSPC_SOP) ||
                (b == bspc_pkg::BSPC_EOP) || (b == bspc_pkg::BSPC_CHAN);
    endfunction

    assign free  = !enc_out_valid || enc_out_ready;
    assign ch_sp = is_sp(enc_in_beat.channel);
    assign d_sp  = is_sp(enc_in_beat.data);
    assign chg   = !hdr_q || (enc_in_beat.channel != chan_q);

    // Byte selection per step; the beat is held by the source until taken
    always_comb begin
        byte_d = bspc_pkg::BSPC_BYTE_RST;
        emit   = 1'b0;
        acc    = 1'b0;
        if (free && enc_in_valid) begin
            emit = 1'b1;
            unique case (st_q)
                bspc_pkg::BSPC_E_IDLE: begin
                    if (enc_in_beat.sop || chg) begin
                        byte_d = bspc_pkg::BSPC_CHAN;
                    end else if (enc_in_beat.eop) begin
                        byte_d = bspc_pkg::BSPC_EOP;
                    end else if (d_sp) begin
                        byte_d = bspc_pkg::BSPC_ESC;
                    end else begin
                        byte_d = enc_in_beat.data;
                        acc    = 1'b1;
                    end
                end
                bspc_pkg::BSPC_E_CHI: begin
                    byte_d = ch_sp ? bspc_pkg::BSPC_ESC : enc_in_beat.channel;
                end
                bspc_pkg::BSPC_E_CHESC: begin
                    byte_d = enc_in_beat.channel ^ bspc_pkg::BSPC_XOR;
                end
                bspc_pkg::BSPC_E_CHNUM: begin
                    // Channel done; continue with the marks
                    if (enc_in_beat.sop) begin
                        byte_d = bspc_pkg::BSPC_SOP;
                    end else if (enc_in_beat.eop) begin
                        byte_d = bspc_pkg::BSPC_EOP;
                    end else if (d_sp) begin
                        byte_d = bspc_pkg::BSPC_ESC;
                    end else begin
                        byte_d = enc_in_beat.data;
                        acc    = 1'b1;
                    end
                end
                bspc_pkg::BSPC_E_SOP: begin
                    if (enc_in_beat.eop) begin
                        byte_d = bspc_pkg::BSPC_EOP;
                    end else if (d_sp) begin
                        byte_d = bspc_pkg::BSPC_ESC;
                    end else begin
                        byte_d = enc_in_beat.data;
                        acc    = 1'b1;
                    end
                end
                bspc_pkg::BSPC_E_EOP: begin
                    if (d_sp) begin
                        byte_d = bspc_pkg::BSPC_ESC;
                    end else begin
                        byte_d = enc_in_beat.data;
                        acc    = 1'b1;
                    end
                end
                bspc_pkg::BSPC_E_DESC: begin
                    byte_d = enc_in_beat.data ^ bspc_pkg::BSPC_XOR;
                    acc    = 1'b1;
                end
                bspc_pkg::BSPC_E_DATA: begin
                    emit = 1'b0;
                end
            endcase
        end
    end

    // input ready only on final byte
    assign enc_in_ready = acc;

    // Step register: records which byte of the beat went last
    // reset returns to header
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= bspc_pkg::BSPC_E_IDLE;
        end else if (acc) begin
            st_q <= bspc_pkg::BSPC_E_IDLE;
        end else if (emit) begin
            unique case (byte_d)
                bspc_pkg::BSPC_CHAN: st_q <= bspc_pkg::BSPC_E_CHI;
                bspc_pkg::BSPC_SOP:  st_q <= bspc_pkg::BSPC_E_SOP;
                bspc_pkg::BSPC_EOP:  st_q <= bspc_pkg::BSPC_E_EOP;
                bspc_pkg::BSPC_ESC: begin
                    st_q <= (st_q == bspc_pkg::BSPC_E_CHI) ?
                            bspc_pkg::BSPC_E_CHESC : bspc_pkg::BSPC_E_DESC;
                end
                default: st_q <= bspc_pkg::BSPC_E_CHNUM;
            endcase
        end
    end

    // Channel memory for change detection
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            chan_q <= bspc_pkg::BSPC_CHAN_RST;
            hdr_q  <= 1'b0;
        end else if (emit && st_q == bspc_pkg::BSPC_E_CHI) begin
            chan_q <= enc_in_beat.channel;
            hdr_q  <= 1'b1;
        end
    end

    // Byte output register
    // ready latency zero handshake
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            enc_out_valid <= 1'b0;
            enc_out_data  <= bspc_pkg::BSPC_BYTE_RST;
        end else if (emit) begin
            enc_out_valid <= 1'b1;
            enc_out_data  <= byte_d;
        end else if (enc_out_ready) begin
            enc_out_valid <= 1'b0;
        end
    end

    // a_enc_hold: byte stable under stall
    a_enc_hold : assert property (@(posedge core_clk) disable iff (!reset_n)
        enc_out_valid && !enc_out_ready |=>
        enc_out_valid && $stable(enc_out_data))
        else $error("encoder byte changed under stall");
    // a_hdr_start: sop beat first sends channel mark
    a_hdr_start : assert property (@(posedge core_clk) disable iff (!reset_n)
        emit && st_q == bspc_pkg::BSPC_E_IDLE && enc_in_beat.sop |=>
        enc_out_data == bspc_pkg::BSPC_CHAN)
        else $error("header missing channel mark");
    // a_eop_mark: eop state precedes data
    a_eop_mark : assert property (@(posedge core_clk) disable iff (!reset_n)
        acc && enc_in_beat.eop && !d_sp |-> st_q == bspc_pkg::BSPC_E_EOP)
        else $error("final byte without end mark");
    // a_esc_data: escaped data follows escape
    a_esc_data : assert property (@(posedge core_clk) disable iff (!reset_n)
        acc && d_sp |=> enc_out_data ==
        ($past(enc_in_beat.data) ^ bspc_pkg::BSPC_XOR))
        else $error("special data not escaped");
    // a_chan_change: new channel resent
    a_chan_change : assert property (@(posedge core_clk)
        disable iff (!reset_n)
        acc |-> hdr_q && chan_q == enc_in_beat.channel)
        else $error("beat sent on stale channel");
    // a_no_drop: ready only with an emitted byte
    a_no_drop : assert property (@(posedge core_clk) disable iff (!reset_n)
        enc_in_ready |-> emit && free)
        else $error("beat taken without output room");
endmodule : bspc_codec
`default_nettype wire

// file: logic/bspc_decoder.sv
// Byte stream to packet stream decoder
`timescale 1ns/1ps
`default_nettype none
module bspc_decoder (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              reset_n,
    // Byte sink
    input  wire logic              in_valid,
    input  wire logic [7:0]        in_data,
    output var  logic              in_ready,
    // Packet source
    output var  logic              out_valid,
    output var  bspc_pkg::bspc_beat_s out_beat,
    input  wire logic              out_ready
);
    logic esc_q;      // Next byte is to be un-escaped
    logic sop_q;      // Next payload carries first-beat flag
    logic eop_q;      // Next payload carries last-beat flag
    logic chcap_q;    // Next data byte is a channel number
    logic [7:0] chan_q;  // Current channel
    logic take;       // Byte accepted this cycle
    logic [7:0] ubyte;   // Byte after un-escape
    logic special;    // Raw special character

    // Output register empties into consumer; accept when free
    assign in_ready = !out_valid || out_ready;
    assign take     = in_valid && in_ready;
    assign ubyte    = esc_q ? (in_data ^ bspc_pkg::BSPC_XOR) : in_data;
    assign special  = !esc_q && (in_data == bspc_pkg::BSPC_ESC ||
                      in_data == bspc_pkg::BSPC_SOP ||
                      in_data == bspc_pkg::BSPC_EOP ||
                      in_data == bspc_pkg::BSPC_CHAN);

    // Marker and escape state
    // reset clears pending state
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            esc_q   <= 1'b0;
            sop_q   <= 1'b0;
            eop_q   <= 1'b0;
            chcap_q <= 1'b0;
        end else if (take) begin
            if (!esc_q && in_data == bspc_pkg::BSPC_ESC) begin
                esc_q <= 1'b1;
            end else if (!esc_q && in_data == bspc_pkg::BSPC_SOP) begin
                sop_q <= 1'b1;
            end else if (!esc_q && in_data == bspc_pkg::BSPC_EOP) begin
                eop_q <= 1'b1;
            end else if (!esc_q && in_data == bspc_pkg::BSPC_CHAN) begin
                chcap_q <= 1'b1;
            end else begin
                esc_q <= 1'b0;
                if (chcap_q) begin
                    chcap_q <= 1'b0;
                end else begin
                    // Flags consumed by this payload beat
                    sop_q <= 1'b0;
                    eop_q <= 1'b0;
                end
            end
        end
    end

    // Channel register
    // eight-bit channel number
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            chan_q <= bspc_pkg::BSPC_CHAN_RST;
        end else if (take && !special && chcap_q) begin
            chan_q <= ubyte;
        end
    end

    // Output beat register
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            out_valid <= 1'b0;
            out_beat  <= '0;
        end else if (take && !special && !chcap_q) begin
            out_valid        <= 1'b1;
            out_beat.data    <= ubyte;
            out_beat.channel <= chan_q;
            out_beat.sop     <= sop_q;
            out_beat.eop     <= eop_q;
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end

    // a_out_hold: beat stays while stalled
    a_out_hold : assert property (@(posedge core_clk) disable iff (!reset_n)
        out_valid && !out_ready |=> out_valid && $stable(out_beat))
        else $error("decoder beat changed under stall");
    // a_esc_xor: escaped byte emitted with xor
    a_esc_xor : assert property (@(posedge core_clk) disable iff (!reset_n)
        take && esc_q && !chcap_q |=> out_valid &&
        out_beat.data == ($past(in_data) ^ bspc_pkg::BSPC_XOR))
        else $error("escaped byte not restored");
    // a_sop_drop: marker bytes never reach output
    a_sop_drop : assert property (@(posedge core_clk) disable iff (!reset_n)
        take && special |=> !out_valid || $stable(out_beat))
        else $error("special byte passed to output");
endmodule : bspc_decoder
`default_nettype wire
